// [include/acc_consts.vh]
// constants for the analog comparator control block
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

// register indices; byte address is four times the index
`define ACC_IDX_CFG_AB 16'ha030
`define ACC_IDX_CFG_CD 16'ha031
`define ACC_IDX_DAC0 16'ha032
`define ACC_IDX_DAC1 16'ha033
`define ACC_IDX_STATUS 16'ha034
`define ACC_IDX_READY 16'ha035

// apb byte address width (index of 16 bits plus two byte-lane bits)
`define ACC_ADDR_W 18

// fields inside one channel nibble of a configuration register
`define ACC_F_ON 3
`define ACC_F_SRC 2
`define ACC_F_IRQ 1
`define ACC_F_INV 0
// nibble bases of the first and second channel of a pair
`define ACC_NIB_HI 4
`define ACC_NIB_LO 0

// status register layout
`define ACC_ST_FLAG_LSB 4
`define ACC_ST_LIVE_LSB 0
`define ACC_ST_HYS_A_LSB 0
`define ACC_ST_HYS_B_LSB 2

// reset values
`define ACC_CFG_RST 8'h00
`define ACC_DAC_RST 8'h00
`define ACC_HYS_RST 2'h0

// comparator bias settling
`define ACC_SETTLE_US 20
`define ACC_CLK_KHZ 20000
`define ACC_SETTLE_CYC ((`ACC_SETTLE_US * `ACC_CLK_KHZ + 999) / 1000)

`endif

// [src/acc_edge.v]
// per-channel toggle detector with sticky flags
`timescale 1ns/1ps
module acc_edge #(
  parameter W = 4
) (
  input wire pclk,
  input wire presetn,
  input wire pclk_en,
  input wire [W-1:0] live,
  input wire [W-1:0] chan_on,
  input wire [W-1:0] clr,
  output wire [W-1:0] flags
);
  reg [W-1:0] prev_q;
  reg [W-1:0] flag_q;
  wire [W-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_ch
      // either direction counts, only while the channel is on
      assign hit[i] = (live[i] ^ prev_q[i]) & chan_on[i]; // [RULE8] [RULE14]
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= {W{1'b0}};
      flag_q <= {W{1'b0}};
    end else if (pclk_en) begin
      prev_q <= live;
      // a new edge beats a clear in the same cycle
      flag_q <= (flag_q & ~clr) | hit; // [RULE14]
    end
  end

  assign flags = flag_q;
endmodule

// [src/acc_sync.v]
// two-stage synchroniser for the raw comparator outputs
`timescale 1ns/1ps
module acc_sync #(
  parameter W = 4
) (
  input wire pclk,
  input wire presetn,
  input wire pclk_en,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else if (pclk_en) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

// [src/acc_top.v]
// analog comparator control: apb registers, polarity, live bits, flags, irq
//
// Operation
// RULE1: four channels, each with enable, threshold select, irq enable, invert.
// RULE2: software waits 20 us after enabling a channel before trusting it.
// RULE3: threshold code drives an 8-bit dac, 0x00 is 0 V, 0xff is 1.8 V.
// RULE4: channel a select 0 takes first dac, 1 takes second dac.
// RULE5: channels b, c, d select 0 takes first dac, 1 external pin.
// RULE6: invert bit set flips the comparator output before report and edges.
// RULE7: cpu reads each live comparator level directly, unlatched.
// RULE8: both edges of each output can raise an interrupt.
// RULE9: a/b config: bits 7..4 channel a, bits 3..0 channel b.
// RULE10: c/d config: bits 7..4 channel c, bits 3..0 channel d.
// RULE11: a and d share one input pin, b and c own pins, fourth is threshold.
// RULE12: software enables the analog switch and tristates other pin drivers.
// RULE13: software leaves an unused threshold code at 0x00 to save power.
// RULE14: flag sets on a live bit toggle while enabled, held until cleared.
// RULE15: a disabled channel reads its live bit as low.
// RULE16: second threshold register drives second dac with the same encoding.
// RULE17: raw outputs pass a two-flop synchroniser before any use.
// RULE18: irq is high while any channel has flag and irq enable set.
`timescale 1ns/1ps
`include "acc_consts.vh"
module acc_top #(
  parameter DAC_W = 8,
  parameter SETTLE_CYC = `ACC_SETTLE_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire pclk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ACC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire comparator_channel_a,
  input wire comparator_channel_b,
  input wire comparator_channel_c,
  input wire comparator_channel_d,
  output wire chan_a_on,
  output wire chan_b_on,
  output wire chan_c_on,
  output wire chan_d_on,
  output wire chan_a_level_source,
  output wire chan_b_level_source,
  output wire chan_c_level_source,
  output wire chan_d_level_source,
  output wire [DAC_W-1:0] first_threshold_level,
  output wire [DAC_W-1:0] second_threshold_level,
  output wire [1:0] chan_a_hysteresis,
  output wire [1:0] chan_bcd_hysteresis,
  output wire irq
);
  localparam NCH = 4;
  localparam SEL_AB = 3'd0;
  localparam SEL_CD = 3'd1;
  localparam SEL_DAC0 = 3'd2;
  localparam SEL_DAC1 = 3'd3;
  localparam SEL_STATUS = 3'd4;
  localparam SEL_READY = 3'd5;
  localparam SEL_NONE = 3'd7;
  // sized from the settle count so a longer setting cannot wrap the counter
  localparam CNT_W = $clog2(SETTLE_CYC + 1) + 1;
  localparam integer SETTLE_M1 = SETTLE_CYC - 1;
  localparam [CNT_W-1:0] SETTLE_LAST = SETTLE_M1[CNT_W-1:0];

  // word-aligned decode of the six registers, used by read and write paths
  function [2:0] acc_decode;
    input [`ACC_ADDR_W-1:0] addr;
    begin
      if (addr == {`ACC_IDX_CFG_AB, 2'b00}) begin
        acc_decode = SEL_AB;
      end else if (addr == {`ACC_IDX_CFG_CD, 2'b00}) begin
        acc_decode = SEL_CD;
      end else if (addr == {`ACC_IDX_DAC0, 2'b00}) begin
        acc_decode = SEL_DAC0;
      end else if (addr == {`ACC_IDX_DAC1, 2'b00}) begin
        acc_decode = SEL_DAC1;
      end else if (addr == {`ACC_IDX_STATUS, 2'b00}) begin
        acc_decode = SEL_STATUS;
      end else if (addr == {`ACC_IDX_READY, 2'b00}) begin
        acc_decode = SEL_READY;
      end else begin
        acc_decode = SEL_NONE;
      end
    end
  endfunction

  // one field of one channel; channel 0..3 is a..d
  // a and c sit in the high nibble of their pair register, b and d in the
  // low nibble, so one field position serves all four channels
  function cfg_field;
    input [7:0] ab;
    input [7:0] cd;
    input integer ch;
    input integer f;
    reg [7:0] pair;
    begin
      if (ch < 2) begin
        pair = ab;
      end else begin
        pair = cd;
      end
      if (ch % 2 == 0) begin
        cfg_field = pair[`ACC_NIB_HI + f];
      end else begin
        cfg_field = pair[`ACC_NIB_LO + f];
      end
    end
  endfunction

  reg [7:0] cfg_ab_q;
  reg [7:0] cfg_cd_q;
  reg [DAC_W-1:0] dac0_q;
  reg [DAC_W-1:0] dac1_q;
  reg [1:0] hys_a_q;
  reg [1:0] hys_b_q;
  reg [NCH-1:0] live_q;
  reg [NCH-1:0] ready_q;
  reg irq_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;
  reg [31:0] rd_val;
  reg [NCH-1:0] clr_d;

  wire [NCH-1:0] raw;
  wire [NCH-1:0] sync;
  wire [NCH-1:0] flags;
  wire [NCH-1:0] on_v;
  wire [NCH-1:0] src_v;
  wire [NCH-1:0] irq_on_v;
  wire [NCH-1:0] inv_v;
  wire [2:0] sel;
  wire setup;
  wire wr_fire;

  // a and d sample the same pin on the analog side and differ only in
  // threshold; b and c have pins of their own
  assign raw = {comparator_channel_d, comparator_channel_c,
                comparator_channel_b, comparator_channel_a}; // [RULE11]

  // channel 0..3 is a..d; each takes one nibble of a config register
  // and the enable, irq enable and invert vectors feed the live, edge and irq logic below
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_cfg // [RULE1]
      assign on_v[c] = cfg_field(cfg_ab_q, cfg_cd_q, c, `ACC_F_ON); // [RULE9] [RULE10]
      assign src_v[c] = cfg_field(cfg_ab_q, cfg_cd_q, c, `ACC_F_SRC); // [RULE9] [RULE10]
      assign irq_on_v[c] = cfg_field(cfg_ab_q, cfg_cd_q, c, `ACC_F_IRQ); // [RULE9] [RULE10]
      assign inv_v[c] = cfg_field(cfg_ab_q, cfg_cd_q, c, `ACC_F_INV); // [RULE9] [RULE10]
    end
  endgenerate

  acc_sync #(
    .W(NCH)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .d(raw),
    .q(sync)
  ); // [RULE17]

  // live bits: polarity applied after the synchroniser, forced low when off
  // a core just switched on shows junk for a few cycles and may raise a flag;
  // software clears such flags once the settle time has passed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_q <= {NCH{1'b0}};
    end else if (pclk_en) begin
      live_q <= on_v & (sync ^ inv_v); // [RULE6] [RULE15] [RULE17]
    end
  end

  acc_edge #(
    .W(NCH)
  ) u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .live(live_q),
    .chan_on(on_v),
    .clr(clr_d),
    .flags(flags)
  ); // [RULE8] [RULE14]

  // irq follows the flags one cycle later so the pin comes from a flop
  // the mask is the per-channel irq enable; flags still set with it clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else if (pclk_en) begin
      irq_q <= |(flags & irq_on_v); // [RULE18]
    end
  end

  // settle timers give software a readable sign that the bias has had
  // its time; they do not gate the live bits, that stays software's call
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_settle
      reg [CNT_W-1:0] cnt_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= {CNT_W{1'b0}};
          ready_q[i] <= 1'b0;
        end else if (pclk_en) begin
          if (!on_v[i]) begin
            cnt_q <= {CNT_W{1'b0}};
            ready_q[i] <= 1'b0;
          end else if (cnt_q != SETTLE_LAST) begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // [RULE2]
          end else begin
            ready_q[i] <= 1'b1; // [RULE2]
          end
        end
      end
    end
  endgenerate

  // apb: answer is prepared in the setup cycle, access phase is one cycle
  // no wait states; a low clock enable simply holds the answer in place
  // read data is taken at the setup edge, so a flag set in the access cycle
  // shows up on the next read instead
  assign sel = acc_decode(paddr);
  assign setup = psel & ~penable;
  assign wr_fire = psel & penable & pready_q & pwrite;

  always @* begin
    rd_val = 32'h0000_0000;
    case (sel)
      SEL_AB: begin
        rd_val[7:0] = cfg_ab_q;
      end
      SEL_CD: begin
        rd_val[7:0] = cfg_cd_q;
      end
      SEL_DAC0: begin
        rd_val[DAC_W-1:0] = dac0_q;
      end
      SEL_DAC1: begin
        rd_val[DAC_W-1:0] = dac1_q;
      end
      SEL_STATUS: begin
        rd_val[`ACC_ST_FLAG_LSB +: NCH] = flags;
        rd_val[`ACC_ST_LIVE_LSB +: NCH] = live_q; // [RULE7]
      end
      SEL_READY: begin
        rd_val[NCH-1:0] = ready_q;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  // write one to a flag bit of the status register clears it
  always @* begin
    clr_d = {NCH{1'b0}};
    if (pclk_en && wr_fire && sel == SEL_STATUS) begin
      clr_d = pwdata[`ACC_ST_FLAG_LSB +: NCH]; // [RULE14]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (pclk_en) begin
      if (setup) begin
        pready_q <= 1'b1;
        pslverr_q <= (sel == SEL_NONE);
        prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
      end else begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // register writes take effect at the access edge only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ab_q <= `ACC_CFG_RST;
      cfg_cd_q <= `ACC_CFG_RST;
      dac0_q <= `ACC_DAC_RST;
      dac1_q <= `ACC_DAC_RST;
      hys_a_q <= `ACC_HYS_RST;
      hys_b_q <= `ACC_HYS_RST;
    end else if (pclk_en && wr_fire) begin
      case (sel)
        SEL_AB: begin
          cfg_ab_q <= pwdata[7:0]; // [RULE9]
        end
        SEL_CD: begin
          cfg_cd_q <= pwdata[7:0]; // [RULE10]
        end
        SEL_DAC0: begin
          dac0_q <= pwdata[DAC_W-1:0]; // [RULE3]
        end
        SEL_DAC1: begin
          dac1_q <= pwdata[DAC_W-1:0]; // [RULE16]
        end
        SEL_STATUS: begin
          // low nibble reads live bits but writes hysteresis trims
          // the trims are write-only; software keeps its own copy
          hys_a_q <= pwdata[`ACC_ST_HYS_A_LSB +: 2];
          hys_b_q <= pwdata[`ACC_ST_HYS_B_LSB +: 2];
        end
        default: begin
          cfg_ab_q <= cfg_ab_q;
        end
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  assign chan_a_on = cfg_ab_q[`ACC_NIB_HI + `ACC_F_ON];
  assign chan_b_on = cfg_ab_q[`ACC_NIB_LO + `ACC_F_ON];
  assign chan_c_on = cfg_cd_q[`ACC_NIB_HI + `ACC_F_ON];
  assign chan_d_on = cfg_cd_q[`ACC_NIB_LO + `ACC_F_ON];

  // a: 0 first dac, 1 second dac; b/c/d: 0 first dac, 1 external pin
  assign chan_a_level_source = cfg_ab_q[`ACC_NIB_HI + `ACC_F_SRC]; // [RULE4]
  assign chan_b_level_source = cfg_ab_q[`ACC_NIB_LO + `ACC_F_SRC]; // [RULE5]
  assign chan_c_level_source = cfg_cd_q[`ACC_NIB_HI + `ACC_F_SRC]; // [RULE5]
  assign chan_d_level_source = cfg_cd_q[`ACC_NIB_LO + `ACC_F_SRC]; // [RULE5]

  // codes go straight to the r-2r dacs, linear over 256 steps
  assign first_threshold_level = dac0_q; // [RULE3]
  assign second_threshold_level = dac1_q; // [RULE16]

  assign chan_a_hysteresis = hys_a_q;
  assign chan_bcd_hysteresis = hys_b_q;
  assign irq = irq_q;
endmodule

// [test/acc_cmp_model.sv]
// behavioural comparator cores and pads feeding the raw comparator outputs
`timescale 1ns/1ps
module acc_cmp_model (
  input wire logic pclk,
  input wire logic [3:0] on,
  input wire logic [3:0] src,
  input wire logic [7:0] th0,
  input wire logic [7:0] th1,
  input wire logic [7:0] pin_ad,
  input wire logic [7:0] pin_b,
  input wire logic [7:0] pin_c,
  input wire logic [7:0] pin_ext,
  input wire logic [3:0] secondary_analog_switch_on,
  output logic [3:0] raw
);
  // a pad whose analog switch is off leaves its comparator at 0 V
  wire [7:0] in_ad = secondary_analog_switch_on[0] ? pin_ad : 8'h00;
  wire [7:0] in_b = secondary_analog_switch_on[1] ? pin_b : 8'h00;
  wire [7:0] in_c = secondary_analog_switch_on[2] ? pin_c : 8'h00;
  wire [7:0] in_ext = secondary_analog_switch_on[3] ? pin_ext : 8'h00;
  logic junk = 1'b0;
  // a powered-down core has no defined output, so it flickers every cycle
  always @(posedge pclk) begin
    junk <= ~junk;
  end
  always @* begin
    raw[0] = on[0] ? (in_ad > (src[0] ? th1 : th0)) : junk;
    raw[1] = on[1] ? (in_b > (src[1] ? in_ext : th0)) : junk;
    raw[2] = on[2] ? (in_c > (src[2] ? in_ext : th0)) : junk;
    raw[3] = on[3] ? (in_ad > (src[3] ? in_ext : th0)) : junk;
  end
endmodule

// [test/acc_top_checker.sv]
// port-level assertions for the comparator control block
`timescale 1ns/1ps
module acc_top_checker #(
  parameter DAC_W = 8,
  parameter SETTLE_CYC = 400
) (
  input wire pclk,
  input wire presetn,
  input wire pclk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire chan_a_on,
  input wire chan_b_on,
  input wire chan_c_on,
  input wire chan_d_on,
  input wire chan_a_level_source,
  input wire chan_b_level_source,
  input wire chan_c_level_source,
  input wire chan_d_level_source,
  input wire [DAC_W-1:0] first_threshold_level,
  input wire [DAC_W-1:0] second_threshold_level,
  input wire irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable && pclk_en;
  wire wr = psel && penable && pready && pwrite && pclk_en;
  wire ok_addr = paddr >= 18'h280c0 && paddr <= 18'h280d4 && paddr[1:0] == 2'b00;
  wire [3:0] w_cfg = {pwdata[7:6], pwdata[3:2]};
  wire [DAC_W-1:0] w_dac = pwdata[DAC_W-1:0];
  wire [3:0] ab = {chan_a_on, chan_a_level_source, chan_b_on, chan_b_level_source};
  wire [3:0] cd = {chan_c_on, chan_c_level_source, chan_d_on, chan_d_level_source};
  a_ready_next: assert property (setup |=> pready)
    else $error("setup not answered in the next cycle");
  a_ready_pulse: assert property (pready && pclk_en |=> !pready)
    else $error("pready held past the access phase");
  a_addr_error: assert property (setup |=> pslverr == !$past(ok_addr))
    else $error("pslverr does not match the address decode");
  a_cfg_ab_write: assert property (wr && paddr == 18'h280c0 |=> ab == $past(w_cfg))
    else $error("a/b config pins do not follow the write");
  a_cfg_cd_write: assert property (wr && paddr == 18'h280c4 |=> cd == $past(w_cfg))
    else $error("c/d config pins do not follow the write");
  a_dac0_write: assert property (wr && paddr == 18'h280c8 |=> first_threshold_level == $past(w_dac))
    else $error("first threshold code does not follow the write");
  a_dac1_write: assert property (wr && paddr == 18'h280cc |=> second_threshold_level == $past(w_dac))
    else $error("second threshold code does not follow the write");
  a_dac0_hold: assert property (!(wr && paddr == 18'h280c8) |=> $stable(first_threshold_level))
    else $error("first threshold code changed without a write");
  c_cfg_write: cover property (wr && paddr == 18'h280c0);
  c_bad_addr: cover property (pready && pslverr);
  c_irq_rise: cover property ($rose(irq));
endmodule

bind acc_top acc_top_checker #(.DAC_W(DAC_W), .SETTLE_CYC(SETTLE_CYC)) chk_u (
  .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .chan_a_on(chan_a_on), .chan_b_on(chan_b_on), .chan_c_on(chan_c_on),
  .chan_d_on(chan_d_on), .chan_a_level_source(chan_a_level_source),
  .chan_b_level_source(chan_b_level_source), .chan_c_level_source(chan_c_level_source),
  .chan_d_level_source(chan_d_level_source), .first_threshold_level(first_threshold_level),
  .second_threshold_level(second_threshold_level), .irq(irq)
);

// [test/acc_top_test.sv]
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module acc_top_test;
  localparam logic [17:0] AB = 18'h280c0;
  localparam logic [17:0] CD = 18'h280c4;
  localparam logic [17:0] D0 = 18'h280c8;
  localparam logic [17:0] D1 = 18'h280cc;
  localparam logic [17:0] ST = 18'h280d0;
  localparam logic [17:0] RDY = 18'h280d4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] pin_ad = 8'h00;
  logic [7:0] pin_b = 8'h00;
  logic [7:0] pin_c = 8'h00;
  logic [7:0] pin_ext = 8'h00;
  logic [3:0] pad_sw = 4'h0;
  logic [7:0] pat [2] = '{8'ha5, 8'h5a};
  logic [17:0] bad [2] = '{18'h280e0, 18'h280c1};
  logic [7:0] v;
  logic [31:0] rd;
  logic err;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire irq;
  wire [3:0] on;
  wire [3:0] src;
  wire [3:0] raw;
  wire [7:0] th0;
  wire [7:0] th1;
  wire [1:0] hys_a;
  wire [1:0] hys_bcd;
  int bad_count = 0;
  int total_checks = 0;
  always #25 pclk = ~pclk;
  // short settle count keeps the ready wait within a few cycles
  acc_top #(.SETTLE_CYC(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_channel_a(raw[0]), .comparator_channel_b(raw[1]),
    .comparator_channel_c(raw[2]), .comparator_channel_d(raw[3]), .chan_a_on(on[0]),
    .chan_b_on(on[1]), .chan_c_on(on[2]), .chan_d_on(on[3]), .chan_a_level_source(src[0]),
    .chan_b_level_source(src[1]), .chan_c_level_source(src[2]),
    .chan_d_level_source(src[3]), .first_threshold_level(th0),
    .second_threshold_level(th1), .chan_a_hysteresis(hys_a), .chan_bcd_hysteresis(hys_bcd),
    .irq(irq)
  );
  acc_cmp_model cm_u (
    .pclk(pclk), .on(on), .src(src), .th0(th0), .th1(th1), .pin_ad(pin_ad),
    .pin_b(pin_b), .pin_c(pin_c), .pin_ext(pin_ext), .secondary_analog_switch_on(pad_sw),
    .raw(raw)
  );
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count is assumed; the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic st(input logic [7:0] e);
    apb(1'b0, ST, 32'h0);
    chk("status", rd, {24'h0, e});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    results();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 18'(AB + 4 * i), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    foreach (pat[k]) begin
      v = pat[k];
      apb(1'b1, AB, {24'h0, v});
      apb(1'b1, CD, {24'h0, ~v});
      apb(1'b1, D0, {24'h0, v});
      apb(1'b1, D1, {24'h0, ~v});
      for (int i = 0; i < 4; i++) begin
        apb(1'b0, 18'(AB + 4 * i), 32'h0);
        chk("readback", rd, {24'h0, i[0] ? ~v : v});
      end
      chk("enables", {28'h0, on}, {28'h0, ~v[3], ~v[7], v[3], v[7]});
      chk("sources", {28'h0, src}, {28'h0, ~v[2], ~v[6], v[2], v[6]});
      chk("thresholds", {16'h0, th1, th0}, {16'h0, ~v, v});
    end
    $display("test registers done");
    foreach (bad[k]) begin
      apb(1'b1, bad[k], 32'hff);
      apb(1'b0, bad[k], 32'h0);
      chk("unmapped read", rd, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
    end
    apb(1'b1, ST, 32'h0b);
    apb(1'b0, D0, 32'h0);
    chk("no stray write", rd, 32'h5a);
    chk("mapped error", {31'h0, err}, 32'h0);
    chk("hysteresis", {28'h0, hys_bcd, hys_a}, 32'hb);
    $display("test bus errors done");
    apb(1'b1, D0, 32'h40);
    apb(1'b1, D1, 32'hc0);
    pin_ad <= 8'h80;
    pin_b <= 8'h50;
    pin_c <= 8'h50;
    pin_ext <= 8'hf0;
    pad_sw <= 4'hf;
    apb(1'b1, AB, 32'he0);
    apb(1'b1, CD, 32'h0e);
    // outputs of freshly enabled cores are not trusted until settled
    repeat (10) @(posedge pclk);
    apb(1'b0, RDY, 32'h0);
    chk("ready", rd, 32'h9);
    apb(1'b1, ST, 32'hf0);
    st(8'h00);
    pin_ad <= 8'hd0;
    repeat (8) @(posedge pclk);
    st(8'h11);
    chk("irq set", {31'h0, irq}, 32'h1);
    apb(1'b1, ST, 32'h10);
    st(8'h01);
    chk("irq clear", {31'h0, irq}, 32'h0);
    pin_ad <= 8'hf8;
    repeat (8) @(posedge pclk);
    st(8'h89);
    pin_ad <= 8'h80;
    repeat (8) @(posedge pclk);
    st(8'h90);
    apb(1'b1, ST, 32'hf0);
    apb(1'b1, AB, 32'hf0);
    repeat (8) @(posedge pclk);
    st(8'h11);
    apb(1'b1, AB, 32'hf8);
    apb(1'b1, CD, 32'hce);
    repeat (8) @(posedge pclk);
    // c was just switched on and its unsettled start set its flag
    apb(1'b1, ST, 32'h40);
    st(8'h33);
    apb(1'b1, ST, 32'h10);
    st(8'h23);
    chk("irq gated", {31'h0, irq}, 32'h0);
    apb(1'b1, AB, 32'h00);
    apb(1'b1, CD, 32'h00);
    repeat (8) @(posedge pclk);
    st(8'h20);
    apb(1'b1, D1, 32'h0);
    apb(1'b1, D0, 32'h0);
    @(posedge pclk);
    chk("idle thresholds", {16'h0, th1, th0}, 32'h0);
    $display("test comparators done");
    results();
  end
endmodule
